// ==== hw/event_timer.sv ====
// Contract
// (R1) 8-bit up-counter clocked by external pin or instruction clock (system clock / 4).
// (R2) Write to counter_value goes to preload; read returns live counter.
// (R3) Mode bits 7:6: 01 event, 10 timer, 11 pulse width, 00 unused.
// (R4) Control bit 3 picks pin edge: 0 rising, 1 falling.
// (R5) Counting only while run_enable (control bit 4) is set.
// (R6) Control bits 2:0 and 5 read as zero.
// (R7) Event and timer modes count up from present value toward FFH.
// (R8) Overflow past FFH reloads from preload and sets overflow_flag together.
// (R9) Event mode counts pin edges; timer mode counts instruction clocks.
// (R10) Pulse mode counts instruction clocks from chosen edge until pin returns, clears run_enable.
// (R11) After a measurement the result holds; one measurement per run_enable set.
// (R12) Pulse counting starts on a detected edge, never on a level.
// (R13) Overflow in pulse mode reloads and flags like the other modes.
// (R14) In event and timer modes hardware never clears run_enable.
// (R15) Overflow acts as a wake-up source for the halted processor.
// (R16) With overflow_irq_enable at 0 no overflow interrupt is requested.
// (R17) Write while stopped loads both preload and counter.
// (R18) Write while running updates preload only; counter runs on.
// (R19) Reading the counter blocks counting that cycle; lost counts stay lost.
// (R20) External pin is synchronised and edge-detected before use.
module event_timer
	import timer_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       resetn,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	output logic      [7:0] rdata,
	input  wire logic       timer_pin,
	input  wire logic       overflow_irq_enable,
	input  wire logic       overflow_flag_clear,
	output logic            overflow_flag,
	output logic            irq_request,
	output logic            wake_up
);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0] count_q,    count_d;
	logic [7:0] preload_q;
	logic [1:0] mode_q;
	logic       edge_sel_q;
	logic       run_q,      run_d;
	logic [1:0] prescale_q;
	logic       ovf_flag_q;
	logic       irq_q;
	logic       wake_q;
	logic [7:0] rdata_q,    rdata_d;
	pw_state_t  pw_q,       pw_d;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire sel_count   = (addr == COUNT_VALUE_PRELOAD_ADDR);
	wire sel_ctrl    = (addr == COUNTER_CONTROL_REG_ADDR);
	wire wr_count    = wr_en & sel_count;
	wire wr_ctrl     = wr_en & sel_ctrl;
	wire rd_count    = rd_en & sel_count;
	wire instr_tick  = (prescale_q == PRESCALE_LAST);      // R1

	wire pin_level;
	wire pin_rise;
	wire pin_fall;

	pin_edge_detect u_pin (                                // R20
		.clock      (clock),
		.resetn     (resetn),
		.pin_in     (timer_pin),
		.pin_level  (pin_level),
		.rise_pulse (pin_rise),
		.fall_pulse (pin_fall)
	);

	wire active_edge  = edge_sel_q ? pin_fall : pin_rise;  // R4
	wire return_edge  = edge_sel_q ? pin_rise : pin_fall;

	wire mode_event   = (mode_q == MODE_EVENT);            // R3
	wire mode_timer   = (mode_q == MODE_TIMER);
	wire mode_pulse   = (mode_q == MODE_PULSE);

	// Pulse measurement ends on the returning edge
	wire pw_end       = mode_pulse & run_q & (pw_q == PW_COUNT) & return_edge;

	// Count request before the read block is applied
	wire count_req    = run_q & (                          // R5
		(mode_event & active_edge) |                       // R9
		(mode_timer & instr_tick) |                        // R9
		(mode_pulse & (pw_q == PW_COUNT) & instr_tick & ~return_edge)); // R10

	// Reading freezes the count clock for a consistent value
	wire count_step   = count_req & ~rd_count;             // R19
	wire overflow     = count_step & (count_q == 8'hFF);   // R8 R13

	wire [7:0] ctrl_view = {mode_q, 1'b0, run_q, edge_sel_q, 3'b000}; // R6

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		count_d = count_q;
		if (overflow) begin
			count_d = preload_q;                           // R8
		end else if (count_step) begin
			count_d = count_q + 8'h01;                     // R7
		end
		if (wr_count && !run_q) begin
			count_d = wdata;                               // R17
		end
	end

	always_comb begin
		pw_d = pw_q;
		case (pw_q)
			PW_IDLE: begin
				// Only an edge starts timing, never a level
				if (mode_pulse && run_q && active_edge) begin // R12
					pw_d = PW_COUNT;
				end
			end
			PW_COUNT: begin
				if (pw_end || !run_q || !mode_pulse) begin
					pw_d = PW_DONE;
				end
			end
			PW_DONE: begin
				// Held until software starts a fresh run
				if (wr_ctrl && wdata[RUN_POS]) begin       // R11
					pw_d = PW_IDLE;
				end
			end
			default: pw_d = PW_IDLE;
		endcase
	end

	always_comb begin
		run_d = run_q;
		if (wr_ctrl) begin
			run_d = wdata[RUN_POS];
		end else if (pw_end) begin
			run_d = 1'b0;                                  // R10 R14
		end
	end

	assign rdata_d = sel_count ? count_q : (sel_ctrl ? ctrl_view : 8'h00); // R2

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!resetn) begin
			prescale_q <= 2'h0;
			count_q    <= COUNT_RESET;
			preload_q  <= COUNT_RESET;
			mode_q     <= CONTROL_RESET[MODE_HI_POS:MODE_LO_POS];
			edge_sel_q <= CONTROL_RESET[EDGE_POS];
			run_q      <= CONTROL_RESET[RUN_POS];
			pw_q       <= PW_IDLE;
		end else begin
			prescale_q <= prescale_q + 2'h1;
			count_q    <= count_d;
			run_q      <= run_d;
			pw_q       <= pw_d;
			if (wr_count) begin
				preload_q <= wdata;                        // R2 R18
			end
			if (wr_ctrl) begin
				mode_q     <= wdata[MODE_HI_POS:MODE_LO_POS]; // R3
				edge_sel_q <= wdata[EDGE_POS];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			ovf_flag_q <= 1'b0;
			irq_q      <= 1'b0;
			wake_q     <= 1'b0;
			rdata_q    <= 8'h00;
		end else begin
			// Set beats a clear in the same cycle
			ovf_flag_q <= overflow | (ovf_flag_q & ~overflow_flag_clear); // R8
			irq_q      <= overflow_irq_enable & (overflow | (ovf_flag_q & ~overflow_flag_clear)); // R16
			wake_q     <= overflow;                        // R15
			rdata_q    <= rd_en ? rdata_d : rdata_q;
		end
	end

	assign rdata         = rdata_q;
	assign overflow_flag = ovf_flag_q;
	assign irq_request   = irq_q;
	assign wake_up       = wake_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_pw_finish;
		pw_end;
	endsequence

	a_overflow_reload: assert property (@(posedge clock) disable iff (!resetn) // R8
		overflow |=> (count_q == $past(preload_q)) && ovf_flag_q)
		else $error("overflow did not reload and flag");

	a_overflow_wake: assert property (@(posedge clock) disable iff (!resetn) // R15
		overflow |=> wake_up)
		else $error("overflow gave no wake-up");

	a_irq_masked: assert property (@(posedge clock) disable iff (!resetn) // R16
		!$past(overflow_irq_enable) |-> !irq_request)
		else $error("interrupt raised while disabled");

	a_idle_hold: assert property (@(posedge clock) disable iff (!resetn) // R5
		!run_q && !wr_count |=> count_q == $past(count_q))
		else $error("counter moved while stopped");

	a_stopped_write: assert property (@(posedge clock) disable iff (!resetn) // R17
		wr_count && !run_q |=> count_q == $past(wdata) && preload_q == $past(wdata))
		else $error("stopped write did not load counter");

	a_read_block: assert property (@(posedge clock) disable iff (!resetn) // R19
		rd_count && run_q && !wr_count |=> count_q == $past(count_q))
		else $error("counter moved during read");

	a_pulse_stop: assert property (@(posedge clock) disable iff (!resetn) // R10
		s_pw_finish and !wr_ctrl |=> !run_q ##0 pw_q == PW_DONE)
		else $error("pulse end did not clear run");

	a_run_kept: assert property (@(posedge clock) disable iff (!resetn) // R14
		run_q && !mode_pulse && !wr_ctrl |=> run_q)
		else $error("run cleared by hardware");

	a_ctrl_zeros: assert property (@(posedge clock) disable iff (!resetn) // R6
		rd_en && sel_ctrl |=> rdata[2:0] == 3'b000 && !rdata[5])
		else $error("unused control bits nonzero");

	// ------------------------------------------------------------
	// Checks: counting
	// ------------------------------------------------------------
	// Quiet cycle: no software access that could move the counter
	wire bus_quiet = ~wr_count & ~rd_count;

	a_tick_period: assert property (@(posedge clock) disable iff (!resetn) // R1
		instr_tick |=> !instr_tick [*3] ##1 instr_tick)
		else $error("instruction clock is not one in four");

	a_timer_step: assert property (@(posedge clock) disable iff (!resetn) // R9
		mode_timer && run_q && instr_tick && bus_quiet && count_q != 8'hFF
		|=> count_q == $past(count_q) + 8'h01)
		else $error("timer missed an instruction clock");

	a_timer_gap: assert property (@(posedge clock) disable iff (!resetn) // R1
		mode_timer && !instr_tick && !wr_count |=> $stable(count_q))
		else $error("timer moved between instruction clocks");

	a_event_step: assert property (@(posedge clock) disable iff (!resetn) // R9
		mode_event && run_q && active_edge && bus_quiet && count_q != 8'hFF
		|=> count_q == $past(count_q) + 8'h01)
		else $error("event edge not counted");

	a_event_edge: assert property (@(posedge clock) disable iff (!resetn) // R4
		mode_event && !active_edge && !wr_count |=> $stable(count_q))
		else $error("event counter moved without active edge");

	a_mode_unused: assert property (@(posedge clock) disable iff (!resetn) // R3
		mode_q == MODE_UNUSED && !wr_count |=> $stable(count_q))
		else $error("counter moved in unused mode");

	a_count_up: assert property (@(posedge clock) disable iff (!resetn) // R7
		run_q && !mode_pulse && bus_quiet && count_q != 8'hFF
		|=> count_q == $past(count_q) || count_q == $past(count_q) + 8'h01)
		else $error("counter did not count up");

	a_running_write: assert property (@(posedge clock) disable iff (!resetn) // R18
		wr_count && run_q && !count_step |=> count_q == $past(count_q) && preload_q == $past(wdata))
		else $error("running write disturbed counter");

	// ------------------------------------------------------------
	// Checks: overflow and flags
	// ------------------------------------------------------------
	sequence s_ovf_pending;
		ovf_flag_q && !overflow_flag_clear;
	endsequence

	a_flag_sticky: assert property (@(posedge clock) disable iff (!resetn) // R8
		s_ovf_pending |=> ovf_flag_q)
		else $error("overflow flag lost without clear");

	a_flag_clear: assert property (@(posedge clock) disable iff (!resetn) // R8
		overflow_flag_clear && !overflow |=> !ovf_flag_q)
		else $error("overflow flag ignored clear");

	a_flag_cause: assert property (@(posedge clock) disable iff (!resetn) // R8
		!ovf_flag_q && !overflow |=> !ovf_flag_q)
		else $error("overflow flag set without overflow");

	a_irq_follow: assert property (@(posedge clock) disable iff (!resetn) // R16
		overflow_irq_enable && ovf_flag_q && !overflow_flag_clear |=> irq_request)
		else $error("enabled flag gave no interrupt");

	a_wake_cause: assert property (@(posedge clock) disable iff (!resetn) // R15
		!overflow |=> !wake_up)
		else $error("wake-up without overflow");

	a_pulse_overflow: assert property (@(posedge clock) disable iff (!resetn) // R13
		mode_pulse && overflow |=> count_q == $past(preload_q) && wake_up)
		else $error("pulse overflow not handled");

	// ------------------------------------------------------------
	// Checks: pulse measurement
	// ------------------------------------------------------------
	sequence s_pw_begin;
		mode_pulse && run_q && pw_q == PW_IDLE && active_edge;
	endsequence

	a_pulse_begin: assert property (@(posedge clock) disable iff (!resetn) // R10
		s_pw_begin |=> pw_q == PW_COUNT)
		else $error("pulse edge did not start timing");

	a_level_no_start: assert property (@(posedge clock) disable iff (!resetn) // R12
		pw_q == PW_IDLE && !active_edge |=> pw_q != PW_COUNT)
		else $error("timing started without an edge");

	a_pulse_step: assert property (@(posedge clock) disable iff (!resetn) // R10
		mode_pulse && run_q && pw_q == PW_COUNT && instr_tick
		&& !return_edge && bus_quiet && count_q != 8'hFF
		|=> count_q == $past(count_q) + 8'h01)
		else $error("pulse timing missed an instruction clock");

	a_result_hold: assert property (@(posedge clock) disable iff (!resetn) // R11
		pw_q == PW_DONE && mode_pulse && !wr_count |=> $stable(count_q))
		else $error("pulse result changed after measurement");

	a_single_shot: assert property (@(posedge clock) disable iff (!resetn) // R11
		pw_q == PW_DONE && !(wr_ctrl && wdata[RUN_POS]) |=> pw_q == PW_DONE)
		else $error("measurement re-armed without run");

	// ------------------------------------------------------------
	// Checks: register access
	// ------------------------------------------------------------
	a_count_read: assert property (@(posedge clock) disable iff (!resetn) // R2
		rd_count |=> rdata == $past(count_q))
		else $error("counter read returned stale value");

	a_rdata_hold: assert property (@(posedge clock) disable iff (!resetn) // R2
		!rd_en |=> $stable(rdata))
		else $error("read data changed without a read");

endmodule

// ==== hw/pin_edge_detect.sv ====
module pin_edge_detect
	import timer_pkg::*;
(
	input  wire logic clock,
	input  wire logic resetn,
	input  wire logic pin_in,
	output logic      pin_level,
	output logic      rise_pulse,
	output logic      fall_pulse
);

	logic meta_q;
	logic sync_q;
	logic last_q;

	// Two-stage synchroniser; only sync_q and its delayed copy last_q are looked at
	always_ff @(posedge clock) begin
		if (!resetn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= pin_in;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign pin_level  = sync_q;
	assign rise_pulse = sync_q & ~last_q;
	assign fall_pulse = ~sync_q & last_q;

endmodule

// ==== hw/timer_pkg.sv ====
package timer_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] COUNT_VALUE_PRELOAD_ADDR = 8'h0D;
	localparam logic [7:0] COUNTER_CONTROL_REG_ADDR = 8'h0E;

	// ------------------------------------------------------------
	// Control fields
	// ------------------------------------------------------------
	localparam int MODE_HI_POS = 7;
	localparam int MODE_LO_POS = 6;
	localparam int RUN_POS     = 4;
	localparam int EDGE_POS    = 3;
	localparam int OVF_FLAG_POS = 5;

	localparam logic [1:0] MODE_UNUSED = 2'h0;
	localparam logic [1:0] MODE_EVENT  = 2'h1;
	localparam logic [1:0] MODE_TIMER  = 2'h2;
	localparam logic [1:0] MODE_PULSE  = 2'h3;

	// ------------------------------------------------------------
	// Reset values and timing
	// ------------------------------------------------------------
	localparam logic [7:0] COUNT_RESET   = 8'h00;
	localparam logic [7:0] CONTROL_RESET = 8'h08;
	localparam logic [1:0] PRESCALE_LAST = 2'h3;
	localparam int         SYS_PER_INSTR = 4;

	typedef enum logic [2:0] {
		PW_IDLE  = 3'b001,
		PW_COUNT = 3'b010,
		PW_DONE  = 3'b100
	} pw_state_t;

endpackage

// ==== verif/pin_source.sv ====
module pin_source (
	input  wire logic       clock,
	input  wire logic       start,
	input  wire logic [7:0] width,
	output logic            pin
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] left_q;

	// Idle low; a start request gives one high pulse of width cycles
	initial pin = 1'b0;
	initial left_q = 8'h00;
	always @(posedge clock) begin
		if (start) begin
			left_q <= width;
			pin <= 1'b1;
		end else if (left_q > 8'h01) begin
			left_q <= left_q - 8'h01;
		end else begin
			left_q <= 8'h00;
			pin <= 1'b0;
		end
	end
endmodule

// ==== verif/testbench.sv ====
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
	$display("Error %s expected %h seen %h", n, e, g); end end

module testbench;
	import timer_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	logic       clock = 1'b0;
	logic       resetn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr_en = 1'b0;
	logic       rd_en = 1'b0;
	logic [7:0] rdata;
	logic       timer_pin;
	logic       irq_en = 1'b1;
	logic       flag_clr = 1'b0;
	logic       overflow_flag;
	logic       irq_request;
	logic       wake_up;
	logic       start = 1'b0;
	logic       wake_seen = 1'b0;
	logic [7:0] v;
	logic [7:0] c1;
	int         err_count = 0;
	int         checks_done = 0;

	always #10 clock = ~clock;
	always @(posedge clock) if (wake_up === 1'b1) wake_seen <= 1'b1;

	event_timer dut (.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .timer_pin(timer_pin), .overflow_irq_enable(irq_en),
		.overflow_flag_clear(flag_clr), .overflow_flag(overflow_flag), .irq_request(irq_request),
		.wake_up(wake_up));
	pin_source src (.clock(clock), .start(start), .width(8'h28), .pin(timer_pin));

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a; wdata <= d; wr_en <= 1'b1;
		@(posedge clock);
		wr_en <= 1'b0;
	endtask

	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		addr <= a; rd_en <= 1'b1;
		@(posedge clock);
		rd_en <= 1'b0;
		#1 d = rdata;
	endtask

	task pulse();
		@(posedge clock);
		start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		repeat (50) @(posedge clock);
	endtask

	task finish_test();
		$display("Comparisons %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Watchdog: about 590 cycles expected
	// ------------------------------------------------------------
	initial begin
		#200000;
		err_count++;
		finish_test();
	end

	initial begin
		repeat (12) @(posedge clock);
		resetn <= 1'b1;
		rd(COUNTER_CONTROL_REG_ADDR, v); `CHK("control reset", CONTROL_RESET, v)
		rd(8'h33, v); `CHK("unmapped read", 8'h00, v)
		wr(COUNT_VALUE_PRELOAD_ADDR, 8'hFD);
		rd(COUNT_VALUE_PRELOAD_ADDR, v); `CHK("stopped load", 8'hFD, v)
		wr(COUNTER_CONTROL_REG_ADDR, 8'h10);
		pulse();
		rd(COUNT_VALUE_PRELOAD_ADDR, v); `CHK("unused mode idle", 8'hFD, v)
		// Bit 5 and low bits written as ones must still read zero
		wr(COUNTER_CONTROL_REG_ADDR, 8'h77);
		rd(COUNTER_CONTROL_REG_ADDR, v); `CHK("control mask", 8'h50, v)
		pulse(); pulse();
		rd(COUNT_VALUE_PRELOAD_ADDR, v); `CHK("event count", 8'hFF, v)
		irq_en <= 1'b0;
		pulse();
		rd(COUNT_VALUE_PRELOAD_ADDR, v); `CHK("reload", 8'hFD, v)
		`CHK("flag set", 1'b1, overflow_flag)
		`CHK("irq masked", 1'b0, irq_request)
		`CHK("wake pulse", 1'b1, wake_seen)
		@(posedge clock);
		irq_en <= 1'b1;
		@(posedge clock);
		#1 `CHK("irq enabled", 1'b1, irq_request)
		@(posedge clock);
		flag_clr <= 1'b1;
		@(posedge clock);
		flag_clr <= 1'b0;
		#1 `CHK("flag cleared", 1'b0, overflow_flag)
		`CHK("irq cleared", 1'b0, irq_request)
		wr(COUNT_VALUE_PRELOAD_ADDR, 8'h10);
		rd(COUNT_VALUE_PRELOAD_ADDR, v); `CHK("running write", 8'hFD, v)
		wr(COUNTER_CONTROL_REG_ADDR, 8'h58);
		pulse();
		rd(COUNT_VALUE_PRELOAD_ADDR, v); `CHK("falling edge count", 8'hFE, v)
		$display("Event test done");

		wr(COUNTER_CONTROL_REG_ADDR, 8'h80);
		wr(COUNT_VALUE_PRELOAD_ADDR, 8'hF0);
		wr(COUNTER_CONTROL_REG_ADDR, 8'h90);
		repeat (40) @(posedge clock);
		rd(COUNTER_CONTROL_REG_ADDR, v); `CHK("run kept", 8'h90, v)
		wr(COUNTER_CONTROL_REG_ADDR, 8'h80);
		// 44 clocks with run set give exactly eleven instruction clocks
		rd(COUNT_VALUE_PRELOAD_ADDR, v); `CHK("timer count", 8'hFB, v)
		$display("Timer test done");

		wr(COUNTER_CONTROL_REG_ADDR, 8'hC0);
		wr(COUNT_VALUE_PRELOAD_ADDR, 8'h00);
		// Pin already high when run is set: a level must not start timing
		@(posedge clock);
		start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		repeat (5) @(posedge clock);
		wr(COUNTER_CONTROL_REG_ADDR, 8'hD0);
		repeat (20) @(posedge clock);
		rd(COUNT_VALUE_PRELOAD_ADDR, v); `CHK("no level start", 8'h00, v)
		repeat (30) @(posedge clock);
		pulse();
		rd(COUNTER_CONTROL_REG_ADDR, v); `CHK("run cleared", 8'hC0, v)
		rd(COUNT_VALUE_PRELOAD_ADDR, c1); `CHK("pulse width", 1'b1, (c1 >= 8'h09 && c1 <= 8'h0B))
		pulse();
		rd(COUNT_VALUE_PRELOAD_ADDR, v); `CHK("single shot", c1, v)
		wr(COUNTER_CONTROL_REG_ADDR, 8'hD0);
		pulse();
		rd(COUNTER_CONTROL_REG_ADDR, v); `CHK("re-armed run cleared", 8'hC0, v)
		rd(COUNT_VALUE_PRELOAD_ADDR, v); `CHK("second measurement", 1'b1, (v >= c1 + 8'h09 && v <= c1 + 8'h0A))
		$display("Pulse test done");
		finish_test();
	end
endmodule
